// File: hw/pcl_pkg.sv
`default_nettype none
// Shared constants of the probe coordinate latch
package pcl_pkg;
   // Sizes
   localparam int NAXES = 2;
   localparam int NPROBES = 2;
   localparam int DI_W = 8;
   localparam int SEL_W = 3;
   localparam int AW = 8;
   // Register byte offsets
   localparam logic [7:0] OFS_ARM = 8'h00;
   localparam logic [7:0] OFS_WIN_LO = 8'h04;
   localparam logic [7:0] OFS_WIN_HI = 8'h08;
   localparam logic [7:0] OFS_SEL = 8'h0c;
   localparam logic [7:0] OFS_FLAGS = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_EN = 8'h18;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;
   localparam logic [7:0] OFS_COORD = 8'h20;
   localparam logic [7:0] OFS_SINCE = 8'h30;
   localparam logic [7:0] OFS_PREV = 8'h38;
   // Field positions
   localparam int ARM_AXIS_BIT = 0;
   localparam int ARM_PROBE_BIT = 1;
   localparam int ARM_MODE_LSB = 2;
   localparam int SEL_ONE_LSB = 0;
   localparam int SEL_TWO_LSB = 4;
   // Values after reset
   localparam logic [2:0] SEL_ONE_RST = 3'h0;
   localparam logic [2:0] SEL_TWO_RST = 3'h1;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Window modes, codes 0, 1, 2 as written to the arm register
   typedef enum logic [1:0] {
      WIN_DISABLE, WIN_EXCLUSIVE, WIN_INCLUSIVE
   } pcl_win_t;
   // Register selector
   typedef enum logic [3:0] {
      REG_ARM, REG_WLO, REG_WHI, REG_SEL, REG_FLG, REG_IST,
      REG_IEN, REG_ICL, REG_CRD, REG_SNC, REG_PRV, REG_NONE
   } pcl_reg_t;
   // Address decode shared by the read and write paths
   function automatic pcl_reg_t pcl_decode(logic [7:0] a);
      pcl_reg_t r;
      r = REG_NONE;
      if (a[7:2] == OFS_ARM[7:2]) r = REG_ARM;
      else if (a[7:2] == OFS_WIN_LO[7:2]) r = REG_WLO;
      else if (a[7:2] == OFS_WIN_HI[7:2]) r = REG_WHI;
      else if (a[7:2] == OFS_SEL[7:2]) r = REG_SEL;
      else if (a[7:2] == OFS_FLAGS[7:2]) r = REG_FLG;
      else if (a[7:2] == OFS_IRQ_STAT[7:2]) r = REG_IST;
      else if (a[7:2] == OFS_IRQ_EN[7:2]) r = REG_IEN;
      else if (a[7:2] == OFS_IRQ_CLR[7:2]) r = REG_ICL;
      else if (a[7:4] == OFS_COORD[7:4]) r = REG_CRD;
      else if (a[7:3] == OFS_SINCE[7:3]) r = REG_SNC;
      else if (a[7:3] == OFS_PREV[7:3]) r = REG_PRV;
      return r;
   endfunction : pcl_decode
endpackage : pcl_pkg
`default_nettype wire

// File: hw/pcl_window_check.sv
`default_nettype none
// Latch window test of one axis and probe pair
module pcl_window_check (
   // Window setting
   input wire logic [1:0] mode,
   input wire logic signed [31:0] lo,
   input wire logic signed [31:0] hi,
   // Axis position
   input wire logic signed [31:0] pos,
   // Result
   output logic in_ok
);
   logic in_bounds; // Bounds inclusive on both ends
   assign in_bounds = (pos >= lo) && (pos <= hi);
   // Choose the capture condition by mode
   always_comb begin
      case (pcl_pkg::pcl_win_t'(mode))
         pcl_pkg::WIN_DISABLE: in_ok = 1'b1;
         pcl_pkg::WIN_EXCLUSIVE: in_ok = !in_bounds;
         pcl_pkg::WIN_INCLUSIVE: in_ok = in_bounds;
         default: in_ok = 1'b0; // Code 3 never captures
      endcase
   end
endmodule : pcl_window_check
`default_nettype wire

// File: hw/pcl_latch.sv
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`default_nettype none
module pcl_latch (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address channel
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // Write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read address channel
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // Read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Digital inputs usable as probes
   input wire logic [7:0] di_in,
   // Machine position per axis
   input wire logic [1:0][31:0] axis_pos,
   // Cancels and program end
   input wire logic [1:0] axis_cancel_request,
   input wire logic channel_reset,
   input wire logic program_end_request,
   output logic program_end_done,
   // Status marks
   output logic probe_one_pending,
   output logic probe_two_pending,
   output logic [1:0] axis_armed_probe_one,
   output logic [1:0] axis_armed_probe_two,
   output logic [1:0] axis_captured_probe_one,
   output logic [1:0] axis_captured_probe_two,
   // Interrupt
   output logic irq
);
   // Entire state of the block
   typedef struct packed {
      logic [1:0][1:0] armed; // [axis][probe]
      logic [1:0][1:0] done;
      logic [1:0][1:0][31:0] coord;
      logic [1:0][1:0][31:0] blo; // Bounds kept per process
      logic [1:0][1:0][31:0] bhi;
      logic [1:0][1:0][1:0] mode;
      logic [1:0][31:0] since;
      logic [1:0][31:0] prev;
      logic [1:0][31:0] pos_last;
      logic pos_ok; // pos_last holds a real sample
      logic [1:0] lvl_last;
      logic [31:0] win_lo;
      logic [31:0] win_hi;
      logic [2:0] sel_one;
      logic [2:0] sel_two;
      logic [1:0] irq_stat; // Capture event per probe
      logic [1:0] irq_en;
      logic aw_full;
      logic w_full;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } pcl_state_t;

   pcl_state_t s_q, s_d;

   // Byte lane merge for writable words
   function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                         logic [3:0] st);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) r[b*8 +: 8] = n[b*8 +: 8];
      end
      return r;
   endfunction : merge

   // Write is performed once both halves are held and no write response is pending
   logic wr_do;
   pcl_pkg::pcl_reg_t wr_reg;
   logic arm_fire, arm_axis, arm_probe;
   logic [1:0] arm_mode;
   assign wr_do = s_q.aw_full && s_q.w_full && !s_q.bvalid;
   assign wr_reg = pcl_pkg::pcl_decode(s_q.awaddr);
   assign arm_fire = wr_do && (wr_reg == pcl_pkg::REG_ARM) && s_q.wstrb[0];
   assign arm_axis = s_q.wdata[pcl_pkg::ARM_AXIS_BIT];
   assign arm_probe = s_q.wdata[pcl_pkg::ARM_PROBE_BIT];
   assign arm_mode = s_q.wdata[pcl_pkg::ARM_MODE_LSB +: 2];

   // Selected probe levels and their rising edges
   logic [1:0] lvl, rise;
   assign lvl = {di_in[s_q.sel_two], di_in[s_q.sel_one]};
   assign rise = lvl & ~s_q.lvl_last;

   // Window test per pair; a pair being armed uses the new setting
   logic [1:0][1:0] arm_now, win_ok, hit;
   logic [1:0] probe_hit;
   for (genvar a = 0; a < pcl_pkg::NAXES; a++) begin : g_ax
      for (genvar p = 0; p < pcl_pkg::NPROBES; p++) begin : g_pr
         assign arm_now[a][p] = arm_fire && (int'(arm_axis) == a)
                                && (int'(arm_probe) == p);
         pcl_window_check u_win (
            .mode(arm_now[a][p] ? arm_mode : s_q.mode[a][p]),
            .lo(arm_now[a][p] ? s_q.win_lo : s_q.blo[a][p]),
            .hi(arm_now[a][p] ? s_q.win_hi : s_q.bhi[a][p]),
            .pos(axis_pos[a]),
            .in_ok(win_ok[a][p])
         );
         // Edge while armed, or level already active at start
         assign hit[a][p] = win_ok[a][p] &&
            ((s_q.armed[a][p] && rise[p]) ||
             (arm_now[a][p] && lvl[p]));
      end
   end
   assign probe_hit[0] = hit[0][0] || hit[1][0];
   assign probe_hit[1] = hit[0][1] || hit[1][1];

   // Position step this cycle, zero until a sample is held
   logic [1:0][31:0] delta;
   assign delta[0] = s_q.pos_ok ? axis_pos[0] - s_q.pos_last[0] : '0;
   assign delta[1] = s_q.pos_ok ? axis_pos[1] - s_q.pos_last[1] : '0;

   // Next state
   always_comb begin
      s_d = s_q;
      s_d.lvl_last = lvl;
      s_d.pos_last = axis_pos;
      s_d.pos_ok = 1'b1;
      // Accept write halves independently
      if (s_axi_awvalid && !s_q.aw_full) begin
         s_d.aw_full = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.w_full) begin
         s_d.w_full = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;
      // Register write
      if (wr_do) begin
         s_d.aw_full = 1'b0;
         s_d.w_full = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = pcl_pkg::RESP_OKAY;
         case (wr_reg)
            pcl_pkg::REG_ARM: begin
               // Start a process: armed up, done down
               if (arm_fire) begin
                  s_d.armed[arm_axis][arm_probe] = 1'b1;
                  s_d.done[arm_axis][arm_probe] = 1'b0;
                  s_d.mode[arm_axis][arm_probe] = arm_mode;
                  s_d.blo[arm_axis][arm_probe] = s_q.win_lo;
                  s_d.bhi[arm_axis][arm_probe] = s_q.win_hi;
               end
            end
            pcl_pkg::REG_WLO:
               s_d.win_lo = merge(s_q.win_lo, s_q.wdata, s_q.wstrb);
            pcl_pkg::REG_WHI:
               s_d.win_hi = merge(s_q.win_hi, s_q.wdata, s_q.wstrb);
            pcl_pkg::REG_SEL: begin
               if (s_q.wstrb[0]) begin
                  s_d.sel_one = s_q.wdata[pcl_pkg::SEL_ONE_LSB +: 3];
                  s_d.sel_two = s_q.wdata[pcl_pkg::SEL_TWO_LSB +: 3];
               end
            end
            pcl_pkg::REG_IEN:
               if (s_q.wstrb[0]) s_d.irq_en = s_q.wdata[1:0];
            pcl_pkg::REG_ICL:
               if (s_q.wstrb[0]) s_d.irq_stat = s_q.irq_stat & ~s_q.wdata[1:0];
            pcl_pkg::REG_SNC:
               s_d.since[s_q.awaddr[2]] =
                  merge(s_q.since[s_q.awaddr[2]], s_q.wdata, s_q.wstrb);
            pcl_pkg::REG_PRV:
               s_d.prev[s_q.awaddr[2]] =
                  merge(s_q.prev[s_q.awaddr[2]], s_q.wdata, s_q.wstrb);
            // Read-only and unmapped words refuse the write
            default: s_d.bresp = pcl_pkg::RESP_SLVERR;
         endcase
      end
      // Travel accumulates every cycle, on top of any write
      for (int a = 0; a < pcl_pkg::NAXES; a++) begin
         s_d.since[a] = s_d.since[a] + delta[a];
      end
      // Capture: all results land in this one cycle
      for (int a = 0; a < pcl_pkg::NAXES; a++) begin
         for (int p = 0; p < pcl_pkg::NPROBES; p++) begin
            if (hit[a][p]) begin
               s_d.coord[a][p] = axis_pos[a];
               s_d.done[a][p] = 1'b1;
            end
         end
         if (|hit[a]) begin
            s_d.prev[a] = s_q.since[a] + delta[a];
            s_d.since[a] = '0;
         end
      end
      // One event ends every process on its probe
      for (int p = 0; p < pcl_pkg::NPROBES; p++) begin
         if (probe_hit[p]) begin
            for (int a = 0; a < pcl_pkg::NAXES; a++) begin
               s_d.armed[a][p] = 1'b0;
            end
         end
      end
      // Cancels come last so they win over a start
      for (int a = 0; a < pcl_pkg::NAXES; a++) begin
         if (axis_cancel_request[a]) s_d.armed[a] = '0;
         if (channel_reset) s_d.armed[a] = '0;
      end
      // Event set wins over a software clear
      s_d.irq_stat = s_d.irq_stat | probe_hit;
      // Read channel, one outstanding read
      if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;
      if (s_axi_arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = pcl_pkg::RESP_OKAY;
         s_d.rdata = '0;
         case (pcl_pkg::pcl_decode(s_axi_araddr))
            pcl_pkg::REG_WLO: s_d.rdata = s_q.win_lo;
            pcl_pkg::REG_WHI: s_d.rdata = s_q.win_hi;
            pcl_pkg::REG_SEL:
               s_d.rdata = {25'h0, s_q.sel_two, 1'b0, s_q.sel_one};
            pcl_pkg::REG_FLG:
               s_d.rdata = {22'h0, s_q.done, s_q.armed,
                            probe_two_pending, probe_one_pending};
            pcl_pkg::REG_IST: s_d.rdata = {30'h0, s_q.irq_stat};
            pcl_pkg::REG_IEN: s_d.rdata = {30'h0, s_q.irq_en};
            pcl_pkg::REG_CRD:
               s_d.rdata = s_q.coord[s_axi_araddr[3]][s_axi_araddr[2]];
            pcl_pkg::REG_SNC: s_d.rdata = s_q.since[s_axi_araddr[2]];
            pcl_pkg::REG_PRV: s_d.rdata = s_q.prev[s_axi_araddr[2]];
            // Write-only words read as zero
            pcl_pkg::REG_ARM, pcl_pkg::REG_ICL: s_d.rdata = '0;
            default: s_d.rresp = pcl_pkg::RESP_SLVERR;
         endcase
      end
   end

   // State register with synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.sel_one <= pcl_pkg::SEL_ONE_RST;
         s_q.sel_two <= pcl_pkg::SEL_TWO_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Bus handshakes
   assign s_axi_awready = !s_q.aw_full;
   assign s_axi_wready = !s_q.w_full;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;

   // Status marks; results of the separate probing cycle live
   // elsewhere and have no path from here
   assign probe_one_pending = |{s_q.armed[1][0], s_q.armed[0][0]};
   assign probe_two_pending = |{s_q.armed[1][1], s_q.armed[0][1]};
   assign axis_armed_probe_one = {s_q.armed[1][0], s_q.armed[0][0]};
   assign axis_armed_probe_two = {s_q.armed[1][1], s_q.armed[0][1]};
   assign axis_captured_probe_one = {s_q.done[1][0], s_q.done[0][0]};
   assign axis_captured_probe_two = {s_q.done[1][1], s_q.done[0][1]};
   assign program_end_done = program_end_request && !(|s_q.armed);
   assign irq = |(s_q.irq_stat & s_q.irq_en);

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_cancel;
      axis_cancel_request[0] |=> s_q.armed[0] == 2'h0;
   endproperty
   a_cancel: assert property (p_cancel)
      else $error("axis cancel left a process armed");
   property p_chan_reset;
      channel_reset |=> !probe_one_pending && !probe_two_pending;
   endproperty
   a_chan_reset: assert property (p_chan_reset)
      else $error("channel reset left a probe pending");
   property p_end_hold;
      program_end_request && (|s_q.armed) |-> !program_end_done;
   endproperty
   a_end_hold: assert property (p_end_hold)
      else $error("program end reported with capture pending");
   property p_pending;
      $rose(axis_armed_probe_two[1]) |-> probe_two_pending;
   endproperty
   a_pending: assert property (p_pending)
      else $error("probe two pending flag missing");
   property p_arm;
      arm_now[0][0] && !probe_hit[0] && !axis_cancel_request[0]
         && !channel_reset |=> axis_armed_probe_one[0]
         && !axis_captured_probe_one[0];
   endproperty
   a_arm: assert property (p_arm)
      else $error("start did not arm or clear done");
   property p_capture;
      hit[1][1] |=> axis_captured_probe_two[1]
         && s_q.coord[1][1] == $past(axis_pos[1]);
   endproperty
   a_capture: assert property (p_capture)
      else $error("captured coordinate or done wrong");
   property p_since;
      |hit[0] |=> s_q.since[0] == 32'h0;
   endproperty
   a_since: assert property (p_since)
      else $error("travel since capture not cleared");
   property p_prev;
      |hit[1] |=> s_q.prev[1] == $past(s_q.since[1]) + $past(delta[1]);
   endproperty
   a_prev: assert property (p_prev)
      else $error("travel between captures wrong");
   property p_probe_cancel;
      probe_hit[0] && !arm_fire |=> axis_armed_probe_one == 2'h0;
   endproperty
   a_probe_cancel: assert property (p_probe_cancel)
      else $error("event left another process armed");
   property p_level_start;
      arm_now[0][1] && lvl[1] && win_ok[0][1] |=>
         axis_captured_probe_two[0]
         && s_q.coord[0][1] == $past(axis_pos[0]);
   endproperty
   a_level_start: assert property (p_level_start)
      else $error("level at start not captured");
   c_capture: cover property (hit[0][0]);
   c_cancel: cover property (axis_armed_probe_one[1]
                             && axis_cancel_request[1]);
   c_end_wait: cover property (program_end_request && !program_end_done
                               ##1 program_end_done);
   c_irq: cover property (irq);
endmodule : pcl_latch
`default_nettype wire

// File: tb/pcl_machine_model.sv
`default_nettype none
// Machine side of the latch: two moving axes and the digital inputs
module pcl_machine_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Commands from the bench
   input wire logic run,
   input wire logic [7:0] di_req,
   // Feedback into the latch
   output logic [1:0][31:0] axis_pos,
   output logic [7:0] di_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Axes move in opposite directions so a sign slip shows up
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         axis_pos[0] <= 32'h0000_1000;
         axis_pos[1] <= 32'h0000_2000;
         di_in <= 8'h00;
      end else begin
         // Motion only while asked, so capture points are known
         if (run) begin
            axis_pos[0] <= axis_pos[0] + 32'h0000_0003;
            axis_pos[1] <= axis_pos[1] - 32'h0000_0002;
         end
         // Inputs pass through one flop, like a real input stage
         di_in <= di_req;
      end
   end
endmodule : pcl_machine_model
`default_nettype wire

// File: tb/probe_coordinate_latch_tb.sv
`default_nettype none
// Self-checking bench of the probe coordinate latch
module probe_coordinate_latch_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // Clock, reset and bus master
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] aw_a = 8'h00;
   logic aw_v = 1'b0;
   logic aw_r, w_r, b_v, ar_r, r_v;
   logic [31:0] w_d = 32'h0;
   logic w_v = 1'b0;
   logic [1:0] b_rsp, r_rsp;
   logic b_r = 1'b0;
   logic [7:0] ar_a = 8'h00;
   logic ar_v = 1'b0;
   logic [31:0] r_d;
   logic r_r = 1'b0;
   // Machine side and control marks
   logic run = 1'b0;
   logic [7:0] di_req = 8'h00;
   logic [7:0] di_in;
   logic [1:0][31:0] pos;
   logic [1:0] cancel = 2'b00;
   logic ch_rst = 1'b0;
   logic pe_req = 1'b0;
   logic pe_done, pend1, pend2, irq;
   logic [1:0] arm1, arm2, done1, done2;
   // Scoreboard
   int err_total = 0;
   int check_count = 0;
   logic [31:0] p0, p1;
   localparam logic [1:0] RSP_ERR = pcl_pkg::RESP_SLVERR;

   // 40 MHz clock
   always #12.5 aclk = ~aclk;

   // Block under test
   pcl_latch u_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
      .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
      .s_axi_wready(w_r), .s_axi_bresp(b_rsp), .s_axi_bvalid(b_v),
      .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_rsp),
      .s_axi_rvalid(r_v), .s_axi_rready(r_r), .di_in(di_in),
      .axis_pos(pos), .axis_cancel_request(cancel),
      .channel_reset(ch_rst), .program_end_request(pe_req),
      .program_end_done(pe_done), .probe_one_pending(pend1),
      .probe_two_pending(pend2), .axis_armed_probe_one(arm1),
      .axis_armed_probe_two(arm2), .axis_captured_probe_one(done1),
      .axis_captured_probe_two(done2), .irq(irq)
   );

   // Probes and axes
   pcl_machine_model u_mach (
      .aclk(aclk), .aresetn(aresetn), .run(run), .di_req(di_req),
      .axis_pos(pos), .di_in(di_in)
   );

   // Verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   // Word compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Flag pair compare
   task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
      chk({30'h0, got}, {30'h0, exp});
   endtask : chk2

   // Let edges pass, then step off the edge so outputs are settled
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask : tick

   // Bus write; address and data offered together, each freed when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = 2'h0);
      int n;
      n = 0;
      @(posedge aclk);
      aw_a <= a;
      aw_v <= 1'b1;
      w_d <= d;
      w_v <= 1'b1;
      b_r <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (aw_v && aw_r) aw_v <= 1'b0;
         if (w_v && w_r) w_v <= 1'b0;
      end while (!b_v && n < 100);
      b_r <= 1'b0;
      if (!b_v) begin
         err_total++;
         test_done();
      end
      chk({30'h0, b_rsp}, {30'h0, er});
      #1;
   endtask : wr

   // Bus read with expected word and answer code
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er = 2'h0);
      int n;
      n = 0;
      @(posedge aclk);
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (ar_v && ar_r) ar_v <= 1'b0;
      end while (!r_v && n < 100);
      r_r <= 1'b0;
      if (!r_v) begin
         err_total++;
         test_done();
      end
      chk(r_d, ed);
      chk({30'h0, r_rsp}, {30'h0, er});
      #1;
   endtask : rd

   // Probe pulse on one digital input
   task automatic fire(input int b);
      @(posedge aclk);
      di_req[b] <= 1'b1;
      tick(3);
      @(posedge aclk);
      di_req[b] <= 1'b0;
      tick(3);
   endtask : fire

   // One-cycle cancel or channel reset
   task automatic pulse(input logic [1:0] c, input logic r);
      @(posedge aclk);
      cancel <= c;
      ch_rst <= r;
      @(posedge aclk);
      cancel <= 2'b00;
      ch_rst <= 1'b0;
      tick(1);
   endtask : pulse

   // Main sequence
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      tick(1);
      // Reset values and refused places
      rd(pcl_pkg::OFS_FLAGS, 32'h0);
      rd(pcl_pkg::OFS_SEL, {25'h0, pcl_pkg::SEL_TWO_RST, 1'b0,
         pcl_pkg::SEL_ONE_RST});
      rd(pcl_pkg::OFS_PREV, 32'h0);
      rd(8'h40, 32'h0, RSP_ERR);
      wr(pcl_pkg::OFS_FLAGS, 32'h1, RSP_ERR);
      wr(pcl_pkg::OFS_COORD, 32'h1, RSP_ERR);
      rd(pcl_pkg::OFS_COORD, 32'h0);
      chk2({1'b0, irq}, 2'b00);
      $display("test reset done");
      // Motion feeds the travel counters; software may overwrite them
      @(posedge aclk);
      run <= 1'b1;
      tick(20);
      @(posedge aclk);
      run <= 1'b0;
      tick(3);
      p0 = pos[0];
      p1 = pos[1];
      rd(pcl_pkg::OFS_SINCE, p0 - 32'h1000);
      rd(pcl_pkg::OFS_SINCE + 8'h04, p1 - 32'h2000);
      wr(pcl_pkg::OFS_SINCE, 32'h100);
      rd(pcl_pkg::OFS_SINCE, 32'h100);
      $display("test travel done");
      // Axis 1 sits inside an exclusive window and is only cancelled
      wr(pcl_pkg::OFS_IRQ_EN, 32'h1);
      wr(pcl_pkg::OFS_WIN_LO, p1 - 32'd5);
      wr(pcl_pkg::OFS_WIN_HI, p1 + 32'd5);
      wr(pcl_pkg::OFS_ARM, 32'h0);
      wr(pcl_pkg::OFS_ARM, 32'h5);
      @(posedge aclk);
      pe_req <= 1'b1;
      tick(1);
      chk2(arm1, 2'b11);
      chk2({pend1, pe_done}, 2'b10);
      fire(0);
      chk2(done1, 2'b01);
      chk2(arm1, 2'b00);
      chk2({pend1, pe_done}, 2'b01);
      chk2({1'b0, irq}, 2'b01);
      rd(pcl_pkg::OFS_COORD, p0);
      rd(pcl_pkg::OFS_SINCE, 32'h0);
      rd(pcl_pkg::OFS_PREV, 32'h100);
      rd(pcl_pkg::OFS_SINCE + 8'h04, p1 - 32'h2000);
      rd(pcl_pkg::OFS_FLAGS, 32'h40);
      rd(pcl_pkg::OFS_IRQ_STAT, 32'h1);
      wr(pcl_pkg::OFS_IRQ_CLR, 32'h1);
      chk2({1'b0, irq}, 2'b00);
      $display("test event done");
      // Probe two already active when armed; its interrupt is masked
      @(posedge aclk);
      di_req[1] <= 1'b1;
      tick(3);
      wr(pcl_pkg::OFS_ARM, 32'h2);
      chk2(done2, 2'b01);
      chk2(arm2, 2'b00);
      rd(pcl_pkg::OFS_COORD + 8'h04, p0);
      chk2({1'b0, irq}, 2'b00);
      rd(pcl_pkg::OFS_IRQ_STAT, 32'h2);
      @(posedge aclk);
      di_req[1] <= 1'b0;
      // Restart clears done; a cancel clears armed, not done
      wr(pcl_pkg::OFS_ARM, 32'h0);
      chk2(done1, 2'b00);
      chk2(arm1, 2'b01);
      pulse(2'b01, 1'b0);
      chk2(arm1, 2'b00);
      chk2({pend1, done2[0]}, 2'b01);
      // Channel reset drops every axis
      wr(pcl_pkg::OFS_ARM, 32'h3);
      wr(pcl_pkg::OFS_ARM, 32'h0);
      chk2({arm2[1], arm1[0]}, 2'b11);
      pulse(2'b00, 1'b1);
      chk2({arm2[1], arm1[0]}, 2'b00);
      chk2({pend2, pe_done}, 2'b01);
      // Capture on axis 1 with probe two, axis 1 standing still
      wr(pcl_pkg::OFS_ARM, 32'h3);
      fire(1);
      chk2(done2, 2'b11);
      chk2(arm2, 2'b00);
      rd(pcl_pkg::OFS_COORD + 8'h0c, p1);
      rd(pcl_pkg::OFS_PREV + 8'h04, p1 - 32'h2000);
      rd(pcl_pkg::OFS_SINCE + 8'h04, 32'h0);
      $display("test cancel done");
      // Every window mode with axis 0 inside the bounds
      wr(pcl_pkg::OFS_WIN_LO, p0 - 32'd5);
      wr(pcl_pkg::OFS_WIN_HI, p0 + 32'd5);
      for (int m = 0; m < 4; m++) begin
         wr(pcl_pkg::OFS_ARM, {28'h0, m[1:0], 2'b00});
         fire(0);
         chk2({1'b0, done1[0]}, {1'b0, m == 0 || m == 2});
         pulse(2'b01, 1'b0);
      end
      $display("test window done");
      test_done();
   end
endmodule : probe_coordinate_latch_tb
`default_nettype wire
